// ### sarcc_ctrl.sv
// successive-approximation converter control with apb registers
//
// What this block does
// R1 - each result is a 10-bit successive-approximation value put into the result pair.
// R2 - all inputs share one multiplexer into a single sample-and-hold feeding the converter.
// R3 - a six-bit channel field picks the input connected to the sample-and-hold.
// R4 - software waits a settling delay after a channel change before starting a conversion.
// R5 - a two-bit field picks reference pin, supply, 2.048V or 4.096V fixed reference.
// R6 - one bit picks the negative reference as the reference pin or ground.
// R7 - a three-bit field picks system clock /2 to /64 or the internal rc clock.
// R8 - a full conversion lasts 11.5 bit periods of the chosen clock.
// R9 - divided options come straight from the system clock; the rc option does not; here it is a system clock /128 stand-in.
// R10 - software picks the rc clock for conversions during sleep.
// R11 - a finished conversion can raise an interrupt that also wakes from sleep.
// R12 - software waits a settling time after selecting the temperature indicator.
// R13 - software disables the pin driver and sets analog select before converting a pin.
// R14 - module_on enables; go/done starts, not in the same write that sets module_on.
// R15 - at completion go/done clears, the done flag sets and the result pair loads.
// R16 - clearing go/done early stores a partial result, unresolved bits copy the last bit.
// R17 - temp range select picks high range at 1, low at 0; a separate bit enables it.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_regs.svh"

module sarcc_ctrl
  import sarcc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // converter core
  input  wire logic        comp_out,
  input  wire logic        device_sleep,
  output sarcc_analog_t    analog_r,
  output logic [9:0]       dac_trial_r,
  output logic             conv_done_flag_r,
  output logic             wake_r
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]   ref_sensor_r;
  logic [7:0]   ctrl_chan_r;
  logic [7:0]   ctrl_clkref_r;
  logic [7:0]   trig_sel_r;
  logic [7:0]   result_high_r;
  logic [7:0]   result_low_r;
  logic         irq_enable_r;
  logic         comp_meta_r;
  logic         comp_sync_r;
  logic         sleep_meta_r;
  logic         sleep_sync_r;
  sarcc_state_t state_r;
  logic [4:0]   half_cnt_r;
  logic [3:0]   bit_idx_r;
  logic [9:0]   sar_r;
  logic [3:0]   delay_r;

  logic         wr_en;
  logic         rd_en;
  logic         half_tick;
  logic         go_set;
  logic         go_clear_sw;
  logic         conv_end;
  logic         rc_mode;
  logic         module_on;
  logic [9:0]   final_val;
  logic [9:0]   partial_val;

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign module_on = ctrl_chan_r[`SARCC_CH_MODULE_ON];
  assign rc_mode   = (ctrl_clkref_r[`SARCC_CR_CLK_LSB +: 2] == 2'b11);
  assign go_set    = wr_en && (paddr == `SARCC_OFS_CTRL_CHAN)
                     && pwdata[`SARCC_CH_GO_DONE] && module_on; // R14
  assign go_clear_sw = wr_en && (paddr == `SARCC_OFS_CTRL_CHAN)
                     && !pwdata[`SARCC_CH_GO_DONE];
  // last resolved half tick of the 23
  assign conv_end  = (state_r == SARCC_CONV) && half_tick
                     && (half_cnt_r == `SARCC_CONV_HALF_PERIODS - 5'd1); // R8

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      comp_meta_r  <= 1'b0;
      comp_sync_r  <= 1'b0;
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      comp_meta_r  <= comp_out;
      comp_sync_r  <= comp_meta_r;
      sleep_meta_r <= device_sleep;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half bit period tick
  sarcc_clkdiv u_clkdiv (
    .clock             (clock),
    .reset_n           (reset_n),
    .run               (state_r == SARCC_CONV),
    .conv_clock_select (ctrl_clkref_r[`SARCC_CR_CLK_LSB +: 3]), // R7 R9
    .half_tick         (half_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ref_sensor_r  <= `SARCC_RST_BYTE;
      ctrl_clkref_r <= `SARCC_RST_BYTE;
      trig_sel_r    <= `SARCC_RST_BYTE;
      irq_enable_r  <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `SARCC_OFS_REF_SENSOR:  ref_sensor_r  <= {pwdata[7], 1'b0, pwdata[5:0]}; // R17
        `SARCC_OFS_CTRL_CLKREF: ctrl_clkref_r <= {pwdata[7:4], 1'b0, pwdata[2:0]}; // R5 R6
        `SARCC_OFS_TRIG_SEL:    trig_sel_r    <= {4'h0, pwdata[3:0]};
        `SARCC_OFS_STATUS:      irq_enable_r  <= pwdata[1];
        default: ;
      endcase
    end
  end

  // channel / module_on / go_done
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_chan_r <= `SARCC_RST_BYTE;
    end else begin
      if (wr_en && (paddr == `SARCC_OFS_CTRL_CHAN)) begin
        ctrl_chan_r[7:2] <= pwdata[7:2]; // R3
        ctrl_chan_r[`SARCC_CH_MODULE_ON] <= pwdata[`SARCC_CH_MODULE_ON];
        ctrl_chan_r[`SARCC_CH_GO_DONE]   <= go_set; // R14
      end
      if (conv_end || !module_on) begin
        ctrl_chan_r[`SARCC_CH_GO_DONE] <= 1'b0; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r    <= SARCC_IDLE;
      half_cnt_r <= 5'd0;
      bit_idx_r  <= 4'd9;
      sar_r      <= 10'h000;
      delay_r    <= 4'd0;
    end else begin
      case (state_r)
        SARCC_IDLE: begin
          half_cnt_r <= 5'd0;
          bit_idx_r  <= 4'd9;
          sar_r      <= 10'h000;
          delay_r    <= `SARCC_RC_START_DELAY;
          if (go_set) begin
            state_r <= rc_mode ? SARCC_DELAY : SARCC_CONV;
          end
        end
        SARCC_DELAY: begin
          delay_r <= delay_r - 4'd1;
          if (go_clear_sw || !module_on) begin
            state_r <= SARCC_IDLE;
          end else if (delay_r == 4'd1) begin
            state_r <= SARCC_CONV;
          end
        end
        SARCC_CONV: begin
          if (go_clear_sw || !module_on || (sleep_sync_r && !rc_mode)) begin
            state_r <= SARCC_IDLE;
          end else if (half_tick) begin
            half_cnt_r <= half_cnt_r + 5'd1;
            // odd half ticks after sampling resolve one bit each
            if (half_cnt_r[0] && half_cnt_r >= 5'd3 && half_cnt_r <= 5'd21) begin
              sar_r[bit_idx_r] <= comp_sync_r; // R1
              if (bit_idx_r != 4'd0) begin
                bit_idx_r <= bit_idx_r - 4'd1;
              end
            end
            if (conv_end) begin
              state_r <= SARCC_IDLE;
            end
          end
        end
        default: state_r <= SARCC_IDLE;
      endcase
    end
  end

  // unresolved bits repeat the last resolved bit
  genvar gi;
  generate
    for (gi = 0; gi < `SARCC_RESULT_BITS; gi = gi + 1) begin : g_part
      assign partial_val[gi] = (gi >= bit_idx_r + 1 || bit_idx_r == 4'd9)
                               ? sar_r[gi]
                               : sar_r[bit_idx_r + 1]; // R16
    end
  endgenerate

  // final bit resolves on the conversion end tick
  always_comb begin
    final_val    = sar_r;
    final_val[0] = comp_sync_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result pair and done flag
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      result_high_r <= `SARCC_RST_BYTE;
      result_low_r  <= `SARCC_RST_BYTE;
    end else if (conv_end) begin
      if (ctrl_clkref_r[`SARCC_CR_JUSTIFY]) begin
        result_high_r <= {6'h00, final_val[9:8]}; // R15
        result_low_r  <= final_val[7:0];
      end else begin
        result_high_r <= final_val[9:2];
        result_low_r  <= {final_val[1:0], 6'h00};
      end
    end else if (state_r == SARCC_CONV && go_clear_sw) begin
      if (ctrl_clkref_r[`SARCC_CR_JUSTIFY]) begin
        result_high_r <= {6'h00, partial_val[9:8]}; // R16
        result_low_r  <= partial_val[7:0];
      end else begin
        result_high_r <= partial_val[9:2];
        result_low_r  <= {partial_val[1:0], 6'h00};
      end
    end else if (wr_en && paddr == `SARCC_OFS_RESULT_HIGH) begin
      result_high_r <= pwdata[7:0];
    end else if (wr_en && paddr == `SARCC_OFS_RESULT_LOW) begin
      result_low_r <= pwdata[7:0];
    end
  end

  // set wins over a same-cycle clear (write 1 to bit 0 clears)
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      conv_done_flag_r <= 1'b0;
      wake_r           <= 1'b0;
    end else begin
      if (conv_end) begin
        conv_done_flag_r <= 1'b1; // R15
      end else if (wr_en && paddr == `SARCC_OFS_STATUS && pwdata[0]) begin
        conv_done_flag_r <= 1'b0;
      end
      wake_r <= (conv_end || conv_done_flag_r) && irq_enable_r; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      analog_r    <= '0;
      dac_trial_r <= 10'h000;
    end else begin
      analog_r.channel_select        <= ctrl_chan_r[7:2]; // R2 R3
      analog_r.positive_ref_select   <= ctrl_clkref_r[`SARCC_CR_PREF_LSB +: 2]; // R5
      analog_r.negative_ref_pin      <= ctrl_clkref_r[`SARCC_CR_NREF]; // R6
      analog_r.temp_indicator_enable <= ref_sensor_r[`SARCC_RS_TEMP_EN]; // R17
      analog_r.temp_range_select     <= ref_sensor_r[`SARCC_RS_TEMP_RANGE]; // R17
      analog_r.sample_hold           <= module_on && (state_r != SARCC_CONV
                                        || half_cnt_r < 5'd3); // R2
      dac_trial_r <= (state_r == SARCC_CONV) ? (sar_r | (10'h001 << bit_idx_r)) : 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path, one wait-free access
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `SARCC_OFS_STATUS || paddr[1:0] != 2'b00);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SARCC_OFS_REF_SENSOR:  prdata <= {24'h0, ref_sensor_r | 8'h40};
          `SARCC_OFS_CTRL_CHAN:   prdata <= {24'h0, ctrl_chan_r};
          `SARCC_OFS_CTRL_CLKREF: prdata <= {24'h0, ctrl_clkref_r};
          `SARCC_OFS_TRIG_SEL:    prdata <= {24'h0, trig_sel_r};
          `SARCC_OFS_RESULT_HIGH: prdata <= {24'h0, result_high_r};
          `SARCC_OFS_RESULT_LOW:  prdata <= {24'h0, result_low_r};
          `SARCC_OFS_STATUS:      prdata <= {28'h0, state_r != SARCC_IDLE,
                                             sleep_sync_r, irq_enable_r,
                                             conv_done_flag_r};
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : sarcc_ctrl
`default_nettype wire

// ### sarcc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SARCC_REGS_SVH
`define SARCC_REGS_SVH

`define SARCC_OFS_REF_SENSOR   12'h000
`define SARCC_OFS_CTRL_CHAN    12'h004
`define SARCC_OFS_CTRL_CLKREF  12'h008
`define SARCC_OFS_TRIG_SEL     12'h00c
`define SARCC_OFS_RESULT_HIGH  12'h010
`define SARCC_OFS_RESULT_LOW   12'h014
`define SARCC_OFS_STATUS       12'h018

// converter_ctrl_channel fields
`define SARCC_CH_MODULE_ON     0
`define SARCC_CH_GO_DONE       1
`define SARCC_CH_SEL_LSB       2
// converter_ctrl_clock_ref fields
`define SARCC_CR_PREF_LSB      0
`define SARCC_CR_NREF          2
`define SARCC_CR_CLK_LSB       4
`define SARCC_CR_JUSTIFY       7
// reference_and_sensor_ctrl fields
`define SARCC_RS_ADC_GAIN_LSB  0
`define SARCC_RS_CMP_GAIN_LSB  2
`define SARCC_RS_TEMP_RANGE    4
`define SARCC_RS_TEMP_EN       5
`define SARCC_RS_REF_READY     6
`define SARCC_RS_REF_EN        7

`define SARCC_RST_BYTE         8'h00
`define SARCC_RESULT_BITS      10
// 11.5 bit periods are counted in half bit periods
`define SARCC_CONV_HALF_PERIODS 5'd23
// start delay whenever the internal rc clock is selected, in system clocks
`define SARCC_RC_START_DELAY   4'd4
// internal rc bit period approximation, in system clocks (half period minus one)
`define SARCC_RC_HALF_DIV      7'd63

`endif

// ### sarcc_pkg.sv
// types shared by the converter control block
package sarcc_pkg;

  typedef enum logic [1:0] {
    SARCC_IDLE  = 2'b00,
    SARCC_DELAY = 2'b01,
    SARCC_CONV  = 2'b11
  } sarcc_state_t;

  typedef struct packed {
    logic [5:0] channel_select;
    logic [1:0] positive_ref_select;
    logic       negative_ref_pin;
    logic       temp_indicator_enable;
    logic       temp_range_select;
    logic       sample_hold;
  } sarcc_analog_t;

endpackage : sarcc_pkg

// ### sarcc_clkdiv.sv
// conversion clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_regs.svh"

module sarcc_clkdiv
  import sarcc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] conv_clock_select,
  // half bit period tick
  output logic            half_tick
);

  logic [6:0] cnt_r;
  logic [6:0] limit;

  // divided options follow the system clock; x11 is the rc stand-in
  always_comb begin
    case (conv_clock_select)
      3'b000:  limit = 7'h00;
      3'b100:  limit = 7'h01;
      3'b001:  limit = 7'h03;
      3'b101:  limit = 7'h07;
      3'b010:  limit = 7'h0f;
      3'b110:  limit = 7'h1f;
      default: limit = `SARCC_RC_HALF_DIV;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n || !run) begin
      cnt_r     <= 7'h00;
      half_tick <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r     <= 7'h00;
      half_tick <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 7'h01;
      half_tick <= 1'b0;
    end
  end

endmodule : sarcc_clkdiv
`default_nettype wire

// ### sarcc_ctrl_assertions.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sarcc_ctrl_assertions
  import sarcc_pkg::*;
(
  // clock and reset
  input wire logic          clock,
  input wire logic          reset_n,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // converter core
  input wire logic          comp_out,
  input wire logic          device_sleep,
  input wire sarcc_analog_t analog_r,
  input wire logic [9:0]    dac_trial_r,
  input wire logic          conv_done_flag_r,
  input wire logic          wake_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  ////////////////////////////////////////
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood two cycles");
  err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // register first, then the registered analog controls: two edges
  chan_write_a: assert property (
    wr && paddr == 12'h004 |=> ##1 analog_r.channel_select == $past(pwdata[7:2], 2))
    else $error("channel select not applied");
  ref_write_a: assert property (
    wr && paddr == 12'h008 |=> ##1 {analog_r.negative_ref_pin, analog_r.positive_ref_select}
    == $past(pwdata[2:0], 2)) else $error("reference select not applied");
  sensor_write_a: assert property (
    wr && paddr == 12'h000 |=> ##1
    {analog_r.temp_indicator_enable, analog_r.temp_range_select}
    == $past(pwdata[5:4], 2)) else $error("sensor bits not applied");
  flag_sticky_a: assert property (
    conv_done_flag_r && !(wr && paddr == 12'h018 && pwdata[0]) |=> conv_done_flag_r)
    else $error("done flag dropped");
  trial_clear_a: assert property ($rose(conv_done_flag_r) |-> ##[0:2] dac_trial_r == 10'h0)
    else $error("trial code left after end");
  cover property ($rose(conv_done_flag_r));
  cover property (pslverr);
  cover property (wake_r);
endmodule : sarcc_ctrl_assertions
`default_nettype wire

// ### sarcc_core_model.sv
// analog core model: ideal comparator against a held input code
`timescale 1ns/1ps
`default_nettype none
module sarcc_core_model
(
  // trial code and held input level
  input  wire logic [9:0] dac_trial_r,
  input  wire logic [9:0] input_code,
  // comparator decision
  output logic            comp_out
);
  // keep trial bit while input is not below it
  assign comp_out = (input_code >= dac_trial_r);
endmodule : sarcc_core_model
`default_nettype wire

// ### sarcc_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_regs.svh"
module sarcc_ctrl_test;
  import sarcc_pkg::*;
  logic          clock = 1'b0, reset_n = 1'b0, device_sleep = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h0;
  logic [31:0]   pwdata = 32'h0, prdata, rdata;
  logic          pready, pslverr, comp_out, conv_done_flag_r, wake_r, err;
  logic [9:0]    dac_trial_r, input_code = 10'h0, t;
  logic [7:0]    v;
  logic [5:0]    ch;
  logic [2:0]    s;
  logic [2:0]    divs [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
  logic [15:0]   r16;
  sarcc_analog_t analog_r;
  int            num_errors = 0, check_count = 0, cycles = 0, n;

  always #4 clock = ~clock;

  sarcc_ctrl dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comp_out(comp_out), .device_sleep(device_sleep),
    .analog_r(analog_r), .dac_trial_r(dac_trial_r), .conv_done_flag_r(conv_done_flag_r),
    .wake_r(wake_r));
  sarcc_core_model core (.dac_trial_r(dac_trial_r), .input_code(input_code),
    .comp_out(comp_out));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk(rdata, {24'h0, e});
  endtask : rd

  function automatic logic [15:0] fmt(input logic [9:0] r, input logic j);
    return j ? {6'h0, r} : {r, 6'h0};
  endfunction : fmt

  // edges from the go write to the done flag, half period per clock option
  function automatic int conv_cycles(input logic [2:0] sel);
    int hp;
    case (sel)
      3'b000:  hp = 1;
      3'b100:  hp = 2;
      3'b001:  hp = 4;
      3'b101:  hp = 8;
      3'b010:  hp = 16;
      3'b110:  hp = 32;
      default: hp = `SARCC_RC_HALF_DIV + 1;
    endcase
    return 1 + `SARCC_CONV_HALF_PERIODS * hp
           + ((sel[1:0] == 2'b11) ? `SARCC_RC_START_DELAY : 0);
  endfunction : conv_cycles

  task automatic wait_done();
    n = 0;
    while (conv_done_flag_r !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  initial begin
    n = $urandom(32'hecf6);
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(12'h000, 8'h40);
    for (int a = 4; a <= 24; a += 4) rd(12'(a), 8'h00);
    apb(1'b0, 12'h01c, 8'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      apb(1'b1, 12'h004, {v[7:2], 2'b00});
      apb(1'b1, 12'h008, v);
      apb(1'b1, 12'h000, v);
      rd(12'h000, v | 8'h40);
      // analog controls settle two edges after each write
      chk({26'h0, analog_r.channel_select}, {26'h0, v[7:2]});
      chk({analog_r.negative_ref_pin, analog_r.positive_ref_select}, v[2:0]);
      chk({analog_r.temp_indicator_enable, analog_r.temp_range_select}, v[5:4]);
    end
    // go in the same write that turns the module on is dropped
    apb(1'b1, 12'h004, 8'h03);
    rd(12'h004, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v  = 8'($urandom);
      ch = 6'($urandom);
      t  = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom);
      // the fastest clock only with codes the comparator lag cannot spoil
      s  = divs[(i < 2) ? ($urandom % 6) : (1 + $urandom % 5)];
      input_code <= t;
      apb(1'b1, 12'h008, {v[7], s, 1'b0, v[2:0]});
      apb(1'b1, 12'h018, 8'h03);
      apb(1'b1, 12'h004, {ch, 2'b01});
      repeat (8) @(posedge clock);
      apb(1'b1, 12'h004, {ch, 2'b11});
      wait_done();
      chk(n, conv_cycles(s));
      repeat (2) @(posedge clock);
      chk({31'h0, wake_r}, 32'h1);
      rd(12'h004, {ch, 2'b01});
      chk({31'h0, analog_r.sample_hold}, 32'h1);
      chk({26'h0, analog_r.channel_select}, {26'h0, ch});
      r16 = fmt(t, v[7]);
      rd(12'h010, r16[15:8]);
      rd(12'h014, r16[7:0]);
    end
    // rc clock keeps converting through sleep
    input_code <= 10'h155;
    apb(1'b1, 12'h000, 8'h20);
    repeat (8) @(posedge clock);
    apb(1'b1, 12'h008, 8'hb0);
    apb(1'b1, 12'h018, 8'h03);
    apb(1'b1, 12'h004, 8'h03);
    device_sleep <= 1'b1;
    wait_done();
    chk(n, conv_cycles(3'b011));
    device_sleep <= 1'b0;
    chk({31'h0, wake_r}, 32'h1);
    rd(12'h010, 8'h01);
    rd(12'h014, 8'h55);
    // sleep stops a conversion on a divided clock
    apb(1'b1, 12'h008, 8'hd0);
    apb(1'b1, 12'h018, 8'h03);
    apb(1'b1, 12'h004, 8'h03);
    repeat (20) @(posedge clock);
    device_sleep <= 1'b1;
    repeat (4) @(posedge clock);
    rd(12'h018, 8'h06);
    device_sleep <= 1'b0;
    // abort mid-conversion: unresolved bits copy the last one
    input_code <= 10'h3ff;
    apb(1'b1, 12'h008, 8'hd0);
    apb(1'b1, 12'h004, 8'h03);
    repeat (100) @(posedge clock);
    chk({31'h0, analog_r.sample_hold}, 32'h0);
    apb(1'b1, 12'h004, 8'h01);
    rd(12'h010, 8'h03);
    rd(12'h014, 8'hff);
    // reset in mid conversion returns the registers to zero
    apb(1'b1, 12'h004, 8'h03);
    repeat (20) @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(12'h004, 8'h00);
    rd(12'h018, 8'h00);
    tally_and_finish();
  end
endmodule : sarcc_ctrl_test

bind sarcc_ctrl sarcc_ctrl_assertions chk_i (.clock(clock), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .comp_out(comp_out), .device_sleep(device_sleep),
  .analog_r(analog_r), .dac_trial_r(dac_trial_r), .conv_done_flag_r(conv_done_flag_r),
  .wake_r(wake_r));
`default_nettype wire
